//--- verilog/seb_pkg.sv
// Shared constants and types for the serial memory bus slave
package seb_pkg;
   // Device-type pattern in the upper nibble of the address byte
   localparam logic [3:0] DEV_TYPE = 4'hA;
   // Address width for the default density
   localparam int ADDR_W_DEF = 8;
   // Smallest density: counter holds at the top instead of wrapping
   localparam int SMALL_ADDR_W = 7;
   // Address width up to which a strap bit is compared (plus strap index)
   localparam int STRAP_BASE = 8;
   // Page layout
   localparam int PAGE_BITS = 4;
   localparam int PAGE_BYTES = 16;
   // Bit counter positions within one nine-pulse byte frame
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] BIT_RST = 4'h0;
   // Pin synchroniser order: {wp, strap2, strap1, strap0, sda, scl}
   localparam logic [5:0] PIN_SYNC_RST = 6'h03;
   // Internal write cycle, longest time
   localparam int TWR_MS = 10;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TWR_CYCLES = TWR_MS * 1000000 / CLK_PERIOD_NS;
   // Protocol states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DEVADDR = 6'h02,
      ST_WORDADDR = 6'h04,
      ST_WDATA = 6'h08,
      ST_RDATA = 6'h10,
      ST_WAIT = 6'h20
   } seb_state_type;
   localparam seb_state_type STATE_RST = ST_IDLE;
endpackage

//--- verilog/seb_eeprom_slave.sv
// Two-wire serial bus slave front end with page buffer and storage array
//
// Overview of operation
// (R1) Start: data falls with clock high
// (R2) Stop: data rises with clock high
// (R3) Data edges during clock high are conditions
// (R4) Master starts only on an idle bus
// (R5) Master ends every operation with stop
// (R6) Address byte upper nibble must match type
// (R7) Next bits: straps or upper array address
// (R8) Last address bit: one reads, zero writes
// (R9) Acknowledge matching address, then read or write
// (R10) Receiver pulls data low on ninth pulse
// (R11) Acknowledge every received write byte
// (R12) Read: send byte, continue only if acknowledged
// (R13) Byte write; stop launches programming
// (R14) No response at all while programming
// (R15) Page write carries up to sixteen bytes
// (R16) Page write increments only low pointer bits
// (R17) Page pointer wraps, overwriting buffered bytes
// (R18) Stop commits all buffered bytes at once
// (R19) Polling: no acknowledge until programming ends
// (R20) Protected: nack first data, no programming
// (R21) Counter holds last address plus one
// (R22) Larger densities wrap, smallest one holds
// (R23) Unprotected: full read and write access
// (R24) Open straps compare as zero
// (R25) Programming within ten ms, bus released
// (R26) Page pointer is low four address bits
`timescale 1ns/1ps
module seb_eeprom_slave
   import seb_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int WR_CYCLES = TWR_CYCLES
) (
   // System clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Bus pins; scl_i also clocks the line driver
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Straps and write protect
   input wire logic strap_pin_0_i,
   input wire logic strap_pin_1_i,
   input wire logic strap_pin_2_i,
   input wire logic wp_i,
   // Status
   output logic busy_o
);
   localparam int TW = $clog2(WR_CYCLES + 1);
   localparam int DEPTH = 1 << ADDR_W;

   logic [5:0] pin_meta_r; // First synchroniser stage
   logic [5:0] pin_sync_r; // Second stage, safe to use
   logic scl_d_r; // Delayed copies for edge detection
   logic sda_d_r;
   logic scl_s;
   logic sda_s;
   logic wp_s;
   logic [2:0] strap_s;
   logic scl_rise;
   logic start_ev;
   logic stop_ev;
   seb_state_type st_r; // Protocol state
   logic [3:0] bit_r; // Pulse index within the byte frame
   logic [7:0] shift_r; // Received bits
   logic [7:0] tx_r; // Byte being sent
   logic first_r; // First read byte still to load
   logic pull_nxt_r; // Pull-down wanted on the line for the next low phase
   logic link_rel_r; // Line driver, link domain
   logic [2:0] hi_r; // Upper address bits from the address byte
   logic [ADDR_W-1:0] ptr_r; // Page write pointer
   logic [ADDR_W-1:0] cnt_r; // Access counter
   logic [ADDR_W-1:0] cnt_inc;
   logic [10:0] full_addr;
   logic [PAGE_BYTES-1:0] pval_r; // Buffered byte valid flags
   logic pend_r; // Data waiting for a stop
   logic busy_r; // Programming in progress
   logic [TW-1:0] tmr_r;
   logic [7:0] mem_r [0:DEPTH-1];
   logic [7:0] pbuf_r [0:PAGE_BYTES-1];
   logic [7:0] rx_byte;
   logic [2:0] strap_bad;
   logic type_ok;
   logic byte_end;
   logic ack_end;
   logic dev_hit;
   logic wa_done;
   logic wd_take;
   logic rd_load;
   logic commit;

   // Two-flop synchronisers on every pin; scl and sda reset high as idle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_meta_r <= PIN_SYNC_RST;
         pin_sync_r <= PIN_SYNC_RST;
      end else begin
         pin_meta_r <= {wp_i, strap_pin_2_i, strap_pin_1_i, strap_pin_0_i, sda_i, scl_i};
         pin_sync_r <= pin_meta_r;
      end
   end

   // Delayed samples; read only from the second stage
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= pin_sync_r[0];
         sda_d_r <= pin_sync_r[1];
      end
   end

   assign scl_s = pin_sync_r[0];
   assign sda_s = pin_sync_r[1];
   assign strap_s = pin_sync_r[4:2];
   assign wp_s = pin_sync_r[5];

   // (R3) Edge classification
   assign scl_rise = scl_s & ~scl_d_r;
   // (R1) Start detect
   assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
   // (R2) Stop detect
   assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // Byte as complete on the eighth rising edge
   assign rx_byte = {shift_r[6:0], sda_s};
   assign byte_end = scl_rise & (bit_r == LAST_BIT);
   assign ack_end = scl_rise & (bit_r == ACK_BIT);
   // (R6) Device-type pattern
   assign type_ok = (rx_byte[7:4] == DEV_TYPE);

   // (R7) Strap bits compared only where the density leaves them free
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_strap
         if (ADDR_W <= STRAP_BASE + gi) begin : g_used
            // (R24) A floating strap arrives as a low level
            assign strap_bad[gi] = (rx_byte[gi+1] != strap_s[gi]);
         end else begin : g_addr
            assign strap_bad[gi] = 1'b0;
         end
      end
   endgenerate

   // (R14) Busy device never matches
   assign dev_hit = (st_r == ST_DEVADDR) & byte_end & type_ok & ~(|strap_bad) & ~busy_r;
   assign wa_done = (st_r == ST_WORDADDR) & byte_end;
   // (R20) Protected data bytes are not taken
   // (R23) Unprotected bytes always taken
   assign wd_take = (st_r == ST_WDATA) & byte_end & ~wp_s;
   // (R12) Load on entry or on master acknowledge
   assign rd_load = (st_r == ST_RDATA) & ack_end & (first_r | ~sda_s);
   // (R18) Stop after buffered data starts programming
   assign commit = stop_ev & pend_r & ~busy_r;
   assign full_addr = {hi_r, rx_byte};

   // (R22) Counter step: wrap to zero, except the smallest density holds
   always_comb begin
      if (ADDR_W == SMALL_ADDR_W && (&cnt_r)) begin
         cnt_inc = cnt_r;
      end else begin
         cnt_inc = cnt_r + 1'b1;
      end
   end

   // Protocol state machine and line decision
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= STATE_RST;
         bit_r <= BIT_RST;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         first_r <= 1'b0;
         pull_nxt_r <= 1'b0;
      end else if (start_ev) begin
         // (R14) Start while busy is ignored until the next start
         // (R19) Polls go unanswered until programming ends
         st_r <= busy_r ? ST_WAIT : ST_DEVADDR;
         bit_r <= BIT_RST;
         pull_nxt_r <= 1'b0;
      end else if (stop_ev) begin
         // (R2) Operation ends
         st_r <= ST_IDLE;
         bit_r <= BIT_RST;
         pull_nxt_r <= 1'b0;
      end else if (scl_rise && st_r != ST_IDLE && st_r != ST_WAIT) begin
         bit_r <= (bit_r == ACK_BIT) ? BIT_RST : bit_r + 4'h1;
         shift_r <= rx_byte;
         unique case (st_r)
            ST_DEVADDR: begin
               if (byte_end) begin
                  // (R9) Acknowledge the match
                  pull_nxt_r <= dev_hit;
                  // (R8) Direction bit picks the path
                  if (!dev_hit) begin
                     st_r <= ST_WAIT;
                  end else if (rx_byte[0]) begin
                     st_r <= ST_RDATA;
                     first_r <= 1'b1;
                  end else begin
                     st_r <= ST_WORDADDR;
                  end
               end
            end
            ST_WORDADDR: begin
               // (R11) Word address acknowledged
               if (byte_end) begin
                  pull_nxt_r <= 1'b1;
                  st_r <= ST_WDATA;
               end else begin
                  pull_nxt_r <= 1'b0;
               end
            end
            ST_WDATA: begin
               if (byte_end) begin
                  // (R20) Protection withholds the acknowledge
                  pull_nxt_r <= ~wp_s;
                  if (wp_s) begin
                     st_r <= ST_WAIT;
                  end
               end else begin
                  pull_nxt_r <= 1'b0;
               end
            end
            ST_RDATA: begin
               if (ack_end) begin
                  first_r <= 1'b0;
                  // (R12) Master nack ends transmission
                  if (rd_load) begin
                     tx_r <= mem_r[cnt_r];
                     pull_nxt_r <= ~mem_r[cnt_r][7];
                  end else begin
                     st_r <= ST_WAIT;
                     pull_nxt_r <= 1'b0;
                  end
               end else if (bit_r == LAST_BIT) begin
                  // (R10) Release for the master's acknowledge
                  pull_nxt_r <= 1'b0;
               end else begin
                  pull_nxt_r <= ~tx_r[6];
                  tx_r <= {tx_r[6:0], 1'b0};
               end
            end
            default: begin
               pull_nxt_r <= 1'b0;
            end
         endcase
      end
   end

   // Line driver on the link clock: changes only on falling scl, so the
   // line never moves while scl is high. The decision above settles
   // within three clk_i edges of the rising scl edge, well inside the
   // high phase, so this capture needs no extra synchroniser.
   always_ff @(negedge scl_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link_rel_r <= 1'b1;
      end else begin
         // (R3) Output moves only with clock low
         link_rel_r <= ~pull_nxt_r;
      end
   end

   // Open drain: enable low pulls the line low
   assign sda_oe_n_o = link_rel_r;
   assign sda_o = link_rel_r;
   assign busy_o = busy_r;

   // Address pointer, access counter and upper header bits
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hi_r <= 3'h0;
         ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         // (R7) Header bits feed the upper array address
         if (dev_hit) begin
            hi_r <= rx_byte[3:1];
         end
         if (wa_done) begin
            ptr_r <= full_addr[ADDR_W-1:0];
            cnt_r <= full_addr[ADDR_W-1:0];
         end else if (wd_take) begin
            // (R16) Only the low bits step
            // (R26) Page pointer is the low nibble
            ptr_r[PAGE_BITS-1:0] <= ptr_r[PAGE_BITS-1:0] + 4'h1;
            // (R21) Counter is last written plus one, wrapping within the page
            cnt_r <= {ptr_r[ADDR_W-1:PAGE_BITS], ptr_r[PAGE_BITS-1:0] + 4'h1};
         end else if (rd_load) begin
            // (R21) Counter is last read plus one
            cnt_r <= cnt_inc;
         end
      end
   end

   // Page buffer valid flags and pending write
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pval_r <= '0;
         pend_r <= 1'b0;
      end else if (wa_done || commit || start_ev) begin
         // A repeated start drops data that no stop has confirmed
         pval_r <= '0;
         pend_r <= 1'b0;
      end else if (wd_take) begin
         // (R15) Up to sixteen distinct bytes
         pval_r[ptr_r[PAGE_BITS-1:0]] <= 1'b1;
         pend_r <= 1'b1;
      end
   end

   // Page buffer data; a wrapped pointer overwrites the older byte
   always_ff @(posedge clk_i) begin
      // (R17) Wrapped writes overwrite
      if (wd_take) begin
         pbuf_r[ptr_r[PAGE_BITS-1:0]] <= rx_byte;
      end
   end

   // Storage array: all valid page entries written in one cycle
   always_ff @(posedge clk_i) begin
      // (R18) Single-cycle commit of the page
      if (commit) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pval_r[i]) begin
               mem_r[{ptr_r[ADDR_W-1:PAGE_BITS], i[PAGE_BITS-1:0]}] <= pbuf_r[i];
            end
         end
      end
   end

   // Programming timer; the bus stays deaf until it runs out
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_r <= 1'b0;
         tmr_r <= '0;
      end else if (commit) begin
         // (R13) Stop launches programming
         busy_r <= 1'b1;
         tmr_r <= TW'(WR_CYCLES - 1);
      end else if (busy_r) begin
         // (R25) Finishes after the set time
         if (tmr_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            tmr_r <= tmr_r - 1'b1;
         end
      end
   end

   // Checks on the protocol engine
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_addr_end;
      (st_r == ST_DEVADDR) && byte_end;
   endsequence

   sequence s_data_end;
      (st_r == ST_WDATA) && byte_end;
   endsequence

   property p_start_arms;
      start_ev && !busy_r |=> st_r == ST_DEVADDR && bit_r == BIT_RST;
   endproperty
   a_start_arms: assert property (p_start_arms) // (R1)
      else $error("start did not arm address phase");

   property p_stop_idles;
      stop_ev |=> st_r == ST_IDLE && !pull_nxt_r;
   endproperty
   a_stop_idles: assert property (p_stop_idles) // (R2)
      else $error("stop did not end the operation");

   property p_type_mismatch;
      s_addr_end and (##0 !type_ok) |=> st_r == ST_WAIT && !pull_nxt_r;
   endproperty
   a_type_mismatch: assert property (p_type_mismatch) // (R6)
      else $error("wrong device type acknowledged");

   property p_dir_read;
      s_addr_end and (##0 dev_hit && rx_byte[0]) |=> st_r == ST_RDATA && pull_nxt_r;
   endproperty
   a_dir_read: assert property (p_dir_read) // (R8)
      else $error("read direction not taken");

   property p_busy_deaf;
      busy_r |-> !pull_nxt_r && st_r != ST_DEVADDR;
   endproperty
   a_busy_deaf: assert property (p_busy_deaf) // (R14)
      else $error("device answered while programming");

   property p_wp_nack;
      s_data_end and (##0 wp_s) |=> !pull_nxt_r && st_r == ST_WAIT
         && pend_r == $past(pend_r);
   endproperty
   a_wp_nack: assert property (p_wp_nack) // (R20)
      else $error("protected data byte acknowledged");

   property p_page_step;
      wd_take |=> ptr_r[PAGE_BITS-1:0] == $past(ptr_r[PAGE_BITS-1:0]) + 4'h1
         && ptr_r[ADDR_W-1:PAGE_BITS] == $past(ptr_r[ADDR_W-1:PAGE_BITS]);
   endproperty
   a_page_step: assert property (p_page_step) // (R16)
      else $error("page pointer step wrong");

   property p_commit_busy;
      commit |=> busy_r && tmr_r == TW'(WR_CYCLES - 1) && !pend_r;
   endproperty
   a_commit_busy: assert property (p_commit_busy) // (R18)
      else $error("stop did not start programming");

   property p_busy_end;
      $fell(busy_r) |-> $past(tmr_r) == '0;
   endproperty
   a_busy_end: assert property (p_busy_end) // (R25)
      else $error("programming ended early");

   property p_read_inc;
      rd_load |=> cnt_r == $past(cnt_inc) && tx_r == $past(mem_r[cnt_r]);
   endproperty
   a_read_inc: assert property (p_read_inc) // (R21)
      else $error("read counter did not advance");

endmodule

//--- bench/seb_bus_master.sv
// Behavioural two-wire bus master that drives the link for the bench
`timescale 1ns/1ps
module seb_bus_master (
   // Link pins; pull_o high means the master pulls data low
   // Idle bus: clock parked high, data left to the pull-up
   output logic scl_o = 1'b1,
   output logic pull_o = 1'b0,
   input wire logic sda_i
);
   // data moves in clock low
   // Odd delays keep the link edges off the system clock grid
   task automatic pulse(input logic pull, output logic seen);
      scl_o = 1'b0;
      #7 pull_o = pull;
      #73 scl_o = 1'b1;
      #41 seen = sda_i;
      #39;
   endtask
   // start from idle
   // A repeated start first lets the line float high in one low phase,
   // since a pulse leaves the clock high with the data possibly held low
   task automatic start_cond();
      logic d;
      if (sda_i !== 1'b1) begin
         pulse(1'b0, d);
      end
      #83 pull_o = 1'b1;
      #77;
   endtask
   task automatic stop_cond();
      logic d;
      pulse(1'b1, d);
      pull_o = 1'b0;
      #163;
   endtask
   // ninth pulse ack
   // Most significant bit goes first
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic d;
      for (int i = 7; i >= 0; i--) pulse(~b[i], d);
      pulse(1'b0, d);
      ack = ~d;
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] b);
      logic d;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b0, d);
         b[i] = d;
      end
      pulse(ack, d);
   endtask
endmodule

//--- bench/tb_seb_eeprom_slave.sv
// Self-checking bench: byte, page, protected and read traffic on the slave
`timescale 1ns/1ps
module tb_seb_eeprom_slave import seb_pkg::*;;
   // Short programming time keeps the run small
   localparam int WR_N = 200;
   localparam logic [2:0] STRAPS = 3'h5;
   localparam logic [7:0] ADR_W = {DEV_TYPE, STRAPS, 1'b0};
   localparam logic [7:0] ADR_R = {DEV_TYPE, STRAPS, 1'b1};
   logic clk_i;
   logic sys_rst_i;
   logic wp_i;
   logic [2:0] strap;
   logic scl;
   logic pull;
   logic sda_w;
   logic sda_o;
   logic sda_oe_n_o;
   logic busy_o;
   int mismatches;
   int n_compared;
   int busy_cnt = 0; // Cycles of the latest programming time
   int n_prog = 0; // Programming times begun
   logic busy_q = 1'b0;
   // Open-drain data wire with pull-up; the device pulls only when enabled and low
   assign sda_w = ~(pull | (~sda_oe_n_o & ~sda_o));

   seb_eeprom_slave #(.ADDR_W(8), .WR_CYCLES(WR_N)) u_seb_eeprom_slave (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .strap_pin_0_i(strap[0]),
      .strap_pin_1_i(strap[1]), .strap_pin_2_i(strap[2]), .wp_i(wp_i),
      .busy_o(busy_o));
   seb_bus_master u_seb_bus_master (.scl_o(scl), .pull_o(pull), .sda_i(sda_w));

   // System clock, 50 MHz
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Length of each programming time in system cycles
   always @(posedge clk_i) begin
      busy_q <= busy_o;
      if (busy_o === 1'b1 && busy_q !== 1'b1) begin
         n_prog <= n_prog + 1;
         busy_cnt <= 1;
      end else if (busy_o === 1'b1) begin
         busy_cnt <= busy_cnt + 1;
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bounded wait for the busy flag; running out ends the run
   task automatic wait_busy(input logic lvl, input int limit);
      int n;
      n = 0;
      while (busy_o !== lvl) begin
         @(negedge clk_i);
         n++;
         if (n > limit) begin
            mismatches++;
            finish_test();
         end
      end
   endtask
   // Start plus address byte, acknowledge compared
   task automatic open_bus(input logic [7:0] a, input logic exp);
      logic ack;
      u_seb_bus_master.start_cond();
      u_seb_bus_master.send_byte(a, ack);
      check("addr ack", 8'(ack), 8'(exp));
   endtask
   // Write: address, word address, data bytes, stop
   task automatic write_seq(input logic [7:0] wa, input logic [7:0] d[$], input logic dack);
      logic ack;
      open_bus(ADR_W, 1'b1);
      u_seb_bus_master.send_byte(wa, ack);
      check("word ack", 8'(ack), 8'h01);
      foreach (d[i]) begin
         u_seb_bus_master.send_byte(d[i], ack);
         check("data ack", 8'(ack), 8'(dack));
      end
      u_seb_bus_master.stop_cond();
   endtask
   // Programming after stop: polls refused while busy, accepted after
   task automatic prog_wait();
      wait_busy(1'b1, 20);
      open_bus(ADR_W, 1'b0);
      u_seb_bus_master.stop_cond();
      wait_busy(1'b0, 2 * WR_N);
      check("busy length", 8'(busy_cnt), 8'(WR_N));
      open_bus(ADR_W, 1'b1);
      u_seb_bus_master.stop_cond();
   endtask
   // Immediate read; last byte answered with nack
   task automatic read_seq(input logic [7:0] e[$]);
      logic [7:0] b;
      open_bus(ADR_R, 1'b1);
      foreach (e[i]) begin
         u_seb_bus_master.recv_byte(i < e.size() - 1, b);
         check("read data", b, e[i]);
      end
      check("line released", 8'(sda_oe_n_o), 8'h01);
      u_seb_bus_master.stop_cond();
   endtask

   initial begin
      logic [7:0] q[$];
      logic ack;
      int p0;
      sys_rst_i = 1'b1;
      wp_i = 1'b0;
      strap = STRAPS;
      mismatches = 0;
      n_compared = 0;
      repeat (4) @(negedge clk_i);
      sys_rst_i = 1'b0;
      check("oe at reset", 8'(sda_oe_n_o), 8'h01);
      check("busy at reset", 8'(busy_o), 8'h00);
      repeat (4) @(negedge clk_i);
      // Wrong type nibble, then wrong straps: both ignored
      open_bus(8'hBA, 1'b0);
      u_seb_bus_master.stop_cond();
      open_bus({DEV_TYPE, 3'h4, 1'b0}, 1'b0);
      u_seb_bus_master.stop_cond();
      // Eighteen bytes into one page: the last two overwrite the first two
      for (int i = 0; i < 18; i++) q.push_back(8'h80 + 8'(i));
      write_seq(8'h20, q, 1'b1);
      prog_wait();
      // Protected write: data refused and nothing programmed
      @(negedge clk_i) wp_i = 1'b1;
      p0 = n_prog;
      write_seq(8'h22, '{8'h77}, 1'b0);
      repeat (20) @(negedge clk_i);
      check("no programming", 8'(n_prog - p0), 8'h00);
      wp_i = 1'b0;
      // Repeated start drops data that no stop has confirmed
      open_bus(ADR_W, 1'b1);
      u_seb_bus_master.send_byte(8'h40, ack);
      check("word ack", 8'(ack), 8'h01);
      u_seb_bus_master.send_byte(8'h55, ack);
      check("data ack", 8'(ack), 8'h01);
      u_seb_bus_master.start_cond();
      u_seb_bus_master.stop_cond();
      repeat (20) @(negedge clk_i);
      check("no commit", 8'(n_prog - p0), 8'h00);
      // Last byte of the page leaves the counter at the page start
      write_seq(8'h2F, '{8'h3C}, 1'b1);
      prog_wait();
      q = '{8'h90, 8'h91};
      for (int i = 2; i < 15; i++) q.push_back(8'h80 + 8'(i));
      q.push_back(8'h3C);
      read_seq(q);
      // Counter passes the top address and wraps to zero
      write_seq(8'hFF, '{8'hC3}, 1'b1);
      prog_wait();
      write_seq(8'h00, '{8'h44}, 1'b1);
      prog_wait();
      write_seq(8'hFE, '{8'h11}, 1'b1);
      prog_wait();
      read_seq('{8'hC3, 8'h44});
      finish_test();
   end
endmodule
